/* inc/split_desc_defs.vh */
// Constants for the split bulk/control descriptor decoder: register offsets,
// descriptor field positions, codes and limits.
// Assumes it is included by its bare name from files under rtl/.
`ifndef SPLIT_DESC_DEFS_VH
`define SPLIT_DESC_DEFS_VH

// Register byte offsets (one aligned 32-bit word each)
`define OFS_DESC_W0       8'h00
`define OFS_DESC_W1       8'h04
`define OFS_DESC_W2       8'h08
`define OFS_DESC_W3       8'h0c
`define OFS_STATUS        8'h10
`define OFS_XLATE         8'h14

// Descriptor word 0
`define W0_ACTIVE         0
`define W0_BYTE_TOTAL     17:3
`define W0_MAX_PAYLOAD    28:18
`define W0_EP_LOW         31
// Descriptor word 1
`define W1_EP_HIGH        2:0
`define W1_FUNC_ADDR      9:3
`define W1_PID            11:10
`define W1_EP_CLASS       13:12
`define W1_SPLIT_SEL      14
`define W1_SPEED_CODE     17:16
`define W1_HUB_PORT       24:18
`define W1_HUB_ADDR       31:25
// Descriptor word 2
`define W2_BUF_PTR        23:8
`define W2_RELOAD         28:25
// Descriptor word 3
`define W3_BYTES_DONE     14:0
`define W3_NAK_COUNT      22:19
`define W3_SPLIT_ERR      24:23
`define W3_WRITE_MASK     32'h01f87fff

// Field codes
`define CLASS_CONTROL     2'h0
`define CLASS_BULK        2'h2
`define PID_OUT           2'h0
`define PID_IN            2'h1
`define PID_SETUP         2'h2
`define SPEED_LOW         2'h2
`define SPEED_FULL        2'h0

// Address translation, size limits and counter constants
`define BUF_CPU_BASE      19'h00400
`define BUF_WORD_SHIFT    3
`define FS_MAX_PAYLOAD    11'h040
`define NAK_IGNORE        4'h0
`define SPLIT_ERR_RESTORE 2'h3

// Transaction result codes from the link engine
`define RES_ACK           3'h0
`define RES_NAK           3'h1
`define RES_NYET          3'h2
`define RES_NO_RESP       3'h3
`define RES_BAD_RESP      3'h4
`define RES_FATAL         3'h5

`endif

/* rtl/descriptor_field_decode.v */
// Combinational decode of descriptor words into transaction fields.
// Assumes all inputs are registered descriptor words on the core clock.
`timescale 1ns/10ps
`default_nettype none
`include "split_desc_defs.vh"

module descriptor_field_decode (
    input  wire [31:0] w0,
    input  wire [31:0] w1,
    input  wire [31:0] w3,
    output wire [6:0]  hub_target_address,
    output wire [6:0]  hub_port_index,
    output wire        split_sel,
    output wire        low_speed,
    output wire        class_ok,
    output wire [1:0]  pid_code,
    output wire        pid_ok,
    output wire [6:0]  function_address,
    output wire [3:0]  endpoint_index,
    output reg  [10:0] packet_len
);
    reg [14:0] remaining;
    reg [10:0] cap;

    // Routing and addressing fields
    assign hub_target_address = w1[`W1_HUB_ADDR];
    assign hub_port_index     = w1[`W1_HUB_PORT];
    assign split_sel          = w1[`W1_SPLIT_SEL];
    // Speed code means nothing for a plain high-speed transaction
    assign low_speed = split_sel & (w1[`W1_SPEED_CODE] == `SPEED_LOW);
    assign class_ok  = (w1[`W1_EP_CLASS] == `CLASS_CONTROL) |
                       (w1[`W1_EP_CLASS] == `CLASS_BULK);
    assign pid_code  = w1[`W1_PID];
    assign pid_ok    = (pid_code == `PID_OUT) | (pid_code == `PID_IN) |
                       (pid_code == `PID_SETUP);
    assign function_address = w1[`W1_FUNC_ADDR];
    // Endpoint index is split across the word boundary
    assign endpoint_index   = {w1[`W1_EP_HIGH], w0[`W0_EP_LOW]};

    // Next packet: what is left of the total, capped by the payload limit
    always @* begin
        remaining = w0[`W0_BYTE_TOTAL] - w3[`W3_BYTES_DONE];
        if (w3[`W3_BYTES_DONE] > w0[`W0_BYTE_TOTAL])
            remaining = 15'h0000;
        cap = w0[`W0_MAX_PAYLOAD];
        if (split_sel && (cap > `FS_MAX_PAYLOAD))
            cap = `FS_MAX_PAYLOAD;
        if (remaining < {4'h0, cap})
            packet_len = remaining[10:0];
        else
            packet_len = cap;
    end
endmodule
`default_nettype wire

/* rtl/retry_counters.v */
// Next-value logic for the NAK retry counter and the split error counter.
// Assumes result_code is valid only while the caller applies the outputs.
`timescale 1ns/10ps
`default_nettype none
`include "split_desc_defs.vh"

module retry_counters (
    input  wire [2:0] result_code,
    input  wire [3:0] reload_count,
    input  wire [3:0] nak_retry_counter,
    input  wire [1:0] split_err,
    output reg  [3:0] nak_next,
    output reg  [1:0] split_err_next,
    output reg        retire
);
    // One decision per transaction outcome
    always @* begin
        nak_next       = nak_retry_counter;
        split_err_next = split_err;
        retire         = 1'b0;
        case (result_code)
            `RES_ACK: begin
                nak_next = reload_count;
            end
            `RES_NAK: begin
                split_err_next = `SPLIT_ERR_RESTORE;
                // A zero reload turns NAK counting off altogether
                if (reload_count != `NAK_IGNORE) begin
                    if (nak_retry_counter <= 4'h1) begin
                        nak_next = 4'h0;
                        retire   = 1'b1;
                    end else begin
                        nak_next = nak_retry_counter - 4'h1;
                    end
                end
            end
            `RES_NYET: begin
                split_err_next = `SPLIT_ERR_RESTORE;
            end
            `RES_NO_RESP, `RES_BAD_RESP: begin
                if (split_err <= 2'h1) begin
                    split_err_next = 2'h0;
                    retire         = 1'b1;
                end else begin
                    split_err_next = split_err - 2'h1;
                end
            end
            `RES_FATAL: begin
                retire = 1'b1;
            end
            default: begin
                retire = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

/* rtl/split_bulk_descriptor_decode.v */
// Transfer descriptor record for split bulk/control transactions: holds the
// descriptor, decodes it for the link engine, and updates it from results.
// Assumes the scheduler and link engine run on core_clk; the register port
// is driven by a master on the same clock.
// Software loads W0 last: its active bit arms the descriptor.
// Results are honoured only while a transaction is outstanding.
// No timeout: a link engine that never answers leaves busy set.
// Link outputs hold from one launch until the next.
//
// Register map (byte offsets, 32-bit words):
//   00 W0  active, byte total, max payload, endpoint bit 0
//   04 W1  endpoint bits 3..1, function, token, class, split, speed, port, hub
//   08 W2  buffer pointer, reload count
//   0c W3  bytes done, NAK count, split error count (masked)
//   10 STATUS and 14 XLATE are read only
// Unmapped offsets read zero and ignore writes.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "split_desc_defs.vh"

module split_bulk_descriptor_decode #(
    parameter ADDR_W = 8
) (
    input  wire              core_clk,
    input  wire              rst_n,
    // Register port
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [31:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [31:0]       reg_rdata,
    // Scheduler side
    input  wire              sched_req,
    output reg               launch,
    output reg               skipped,
    output reg               busy,
    // Decoded transaction for the link engine
    output reg  [6:0]        hub_target_address,
    output reg  [6:0]        hub_port_index,
    output reg               split_en,
    output reg               low_speed,
    output reg  [1:0]        pid_code,
    output reg               ep_is_bulk,
    output reg  [6:0]        function_address,
    output reg  [3:0]        endpoint_index,
    output reg  [10:0]       packet_len,
    output reg  [15:0]       payload_buffer_pointer,
    // Result from the link engine
    input  wire              result_valid,
    input  wire [2:0]        result_code,
    input  wire [10:0]       result_bytes,
    output reg               active
);
    // One transaction outstanding at most, so one state bit
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    // Descriptor words; W0 and W3 are updated in place by results
    reg  [31:0] w0_reg;
    reg  [31:0] w1_reg;
    reg  [31:0] w2_reg;
    reg  [31:0] w3_reg;
    reg         state_reg;
    reg         state_next;
    reg  [31:0] rdata_next;
    reg  [15:0] done_sum;

    // Decoder and counter outputs
    wire [6:0]  dec_hub;
    wire [6:0]  dec_port;
    wire        dec_split;
    wire        dec_low;
    wire        dec_class_ok;
    wire [1:0]  dec_pid;
    wire        dec_pid_ok;
    wire [6:0]  dec_func;
    wire [3:0]  dec_ep;
    wire [10:0] dec_len;
    wire [3:0]  nak_next;
    wire [1:0]  err_next;
    wire        retire;
    wire        desc_live;
    wire        take_result;
    wire [18:0] buf_cpu_addr;
    wire        launch_take;
    wire        desc_done;

    // Field extraction and packet sizing from the stored words
    descriptor_field_decode u_decode (
        .w0                 (w0_reg),
        .w1                 (w1_reg),
        .w3                 (w3_reg),
        .hub_target_address (dec_hub),
        .hub_port_index     (dec_port),
        .split_sel          (dec_split),
        .low_speed          (dec_low),
        .class_ok           (dec_class_ok),
        .pid_code           (dec_pid),
        .pid_ok             (dec_pid_ok),
        .function_address   (dec_func),
        .endpoint_index     (dec_ep),
        .packet_len         (dec_len)
    );

    // Counter bookkeeping for one result; applied only while a result
    // is taken, so stale codes between results do no harm
    retry_counters u_retry (
        .result_code       (result_code),
        .reload_count      (w2_reg[`W2_RELOAD]),
        .nak_retry_counter (w3_reg[`W3_NAK_COUNT]),
        .split_err         (w3_reg[`W3_SPLIT_ERR]),
        .nak_next          (nak_next),
        .split_err_next    (err_next),
        .retire            (retire)
    );

    // A descriptor with an unknown class or PID is never launched either
    assign desc_live   = w0_reg[`W0_ACTIVE] & dec_class_ok & dec_pid_ok;
    // A result that turns up while idle is dropped
    assign take_result = (state_reg == ST_BUSY) & result_valid;

    // The one launch decision, shared by the launch pulse and the field latch
    assign launch_take = (state_reg == ST_IDLE) & sched_req & desc_live;

    // An acknowledged packet reaching the byte total ends the descriptor;
    // the spare sum bit ends it too should the count overflow
    assign desc_done = (result_code == `RES_ACK) &
                       (done_sum[15] | (done_sum[14:0] >= w0_reg[`W0_BYTE_TOTAL]));

    // Processor byte address of the buffer, shown for software checking
    assign buf_cpu_addr = ({3'h0, w2_reg[`W2_BUF_PTR]} << `BUF_WORD_SHIFT)
                          + `BUF_CPU_BASE;

    // Bytes moved so far plus this packet; one spare bit catches overflow
    // Feeds both the W3 update and the completion test
    always @* begin
        done_sum = {1'b0, w3_reg[`W3_BYTES_DONE]} + {5'h00, result_bytes};
    end

    // Launch sequencing: one transaction outstanding at a time
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // A request for a dead descriptor is answered with a skip
                if (sched_req && desc_live)
                    state_next = ST_BUSY;
            end
            ST_BUSY: begin
                // Only a result ends the transaction
                if (result_valid)
                    state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Launch is a one-cycle pulse; skip is high for each idle cycle with a dead request; busy mirrors the state.
    // A request is looked at only while idle, so one during busy is lost.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            launch    <= 1'b0;
            skipped   <= 1'b0;
            busy      <= 1'b0;
        end else begin
            state_reg <= state_next;
            launch    <= launch_take;
            skipped   <= (state_reg == ST_IDLE) & sched_req & ~desc_live;
            busy      <= (state_next == ST_BUSY);
        end
    end

    // Descriptor storage. A software write in the same cycle as a result
    // wins, since software is loading a fresh descriptor over the old one.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w0_reg <= 32'h00000000;
            w1_reg <= 32'h00000000;
            w2_reg <= 32'h00000000;
            w3_reg <= 32'h00000000;
        end else begin
            if (take_result) begin
                // Counts update on every result, ACK or not
                w3_reg[`W3_NAK_COUNT] <= nak_next;
                w3_reg[`W3_SPLIT_ERR] <= err_next;
                if (retire)
                    w0_reg[`W0_ACTIVE] <= 1'b0;
                // Bytes done move only on ACK, so a retry counts once
                if (result_code == `RES_ACK) begin
                    w3_reg[`W3_BYTES_DONE] <= done_sum[14:0];
                    // Whole descriptor done once the total has been moved
                    if (done_sum[15] ||
                        (done_sum[14:0] >= w0_reg[`W0_BYTE_TOTAL]))
                        w0_reg[`W0_ACTIVE] <= 1'b0;
                end
            end

            // Unmapped and read-only offsets are ignored. The default arm
            // assigns nothing: rewriting a word there would undo a
            // hardware clear taken in the same cycle.
            if (reg_wr) begin
                case (reg_addr)
                    `OFS_DESC_W0: w0_reg <= reg_wdata;
                    `OFS_DESC_W1: w1_reg <= reg_wdata;
                    `OFS_DESC_W2: w2_reg <= reg_wdata;
                    `OFS_DESC_W3: w3_reg <= reg_wdata & `W3_WRITE_MASK;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Decoded fields are latched at launch so they hold during the transaction
    // A rewrite of the words mid-transaction shows only at the next launch
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hub_target_address     <= 7'h00;
            hub_port_index         <= 7'h00;
            split_en               <= 1'b0;
            low_speed              <= 1'b0;
            pid_code               <= 2'h0;
            ep_is_bulk             <= 1'b0;
            function_address       <= 7'h00;
            endpoint_index         <= 4'h0;
            packet_len             <= 11'h000;
            payload_buffer_pointer <= 16'h0000;
        end else if (launch_take) begin
            hub_target_address     <= dec_hub;
            hub_port_index         <= dec_port;
            split_en               <= dec_split;
            low_speed              <= dec_low;
            pid_code               <= dec_pid;
            ep_is_bulk             <= (w1_reg[`W1_EP_CLASS] == `CLASS_BULK);
            function_address       <= dec_func;
            endpoint_index         <= dec_ep;
            packet_len             <= dec_len;
            payload_buffer_pointer <= w2_reg[`W2_BUF_PTR];
        end
    end

    // Active flag mirror for the scheduler; a clear shows in the same
    // cycle as the stored bit, so the two never disagree after a result
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            active <= 1'b0;
        else if (reg_wr && (reg_addr == `OFS_DESC_W0))
            active <= reg_wdata[`W0_ACTIVE];
        else if (take_result && (retire || desc_done))
            active <= 1'b0;
        else
            active <= w0_reg[`W0_ACTIVE];
    end

    // Read mux; unmapped offsets read zero
    // STATUS: low speed, split, busy state, active in bits 3..0
    always @* begin
        case (reg_addr)
            `OFS_DESC_W0: rdata_next = w0_reg;
            `OFS_DESC_W1: rdata_next = w1_reg;
            `OFS_DESC_W2: rdata_next = w2_reg;
            `OFS_DESC_W3: rdata_next = w3_reg;
            `OFS_STATUS:  rdata_next = {28'h0000000, dec_low, dec_split,
                                        state_reg, w0_reg[`W0_ACTIVE]};
            `OFS_XLATE:   rdata_next = {13'h0000, buf_cpu_addr};
            default:      rdata_next = 32'h00000000;
        endcase
    end

    // Read data stands for exactly the cycle after the strobe
    // Zero outside the slot keeps a stale word off the bus
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 32'h00000000;
    end
endmodule
`default_nettype wire

/* testbench/split_bulk_descriptor_decode_checker.sv */
// Checker for the split descriptor decoder: request, result and decode timing.
// Assumes it is bound onto the decoder and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module split_bulk_descriptor_decode_checker #(
    parameter ADDR_W = 8
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        sched_req,
    input wire logic        launch,
    input wire logic        skipped,
    input wire logic        busy,
    input wire logic [6:0]  hub_target_address,
    input wire logic        split_en,
    input wire logic        low_speed,
    input wire logic [1:0]  pid_code,
    input wire logic [10:0] packet_len,
    input wire logic [15:0] payload_buffer_pointer,
    input wire logic        result_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // A request taken while idle gets exactly one answer pulse
    sequence s_taken;
        sched_req && !busy;
    endsequence
    sequence s_answer;
        launch ^ skipped;
    endsequence
    a_req_answered: assert property (s_taken |=> s_answer)
        else $error("idle request got no single answer");
    a_busy_ignores: assert property (sched_req && busy |=> !launch && !skipped)
        else $error("request answered while busy");
    a_launch_cause: assert property (launch |-> $past(sched_req) && !$past(busy) && busy)
        else $error("launch without an idle request");
    a_result_ends: assert property (busy && result_valid |=> !busy)
        else $error("busy held after result");
    a_low_split: assert property (launch && low_speed |-> split_en)
        else $error("low speed outside a split");
    a_pid_legal: assert property (launch |-> pid_code != 2'h3)
        else $error("launch with reserved token code");
    a_split_cap: assert property (launch && split_en |-> packet_len <= 11'h040)
        else $error("split packet above 64 bytes");
    a_fields_held: assert property (!launch |-> $stable(hub_target_address) &&
        $stable(payload_buffer_pointer))
        else $error("decoded fields moved between launches");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
endmodule
bind split_bulk_descriptor_decode split_bulk_descriptor_decode_checker #(.ADDR_W(ADDR_W)) chk_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sched_req(sched_req), .launch(launch), .skipped(skipped), .busy(busy),
    .hub_target_address(hub_target_address), .split_en(split_en), .low_speed(low_speed),
    .pid_code(pid_code), .packet_len(packet_len),
    .payload_buffer_pointer(payload_buffer_pointer), .result_valid(result_valid));
`default_nettype wire

/* testbench/link_engine_model.sv */
// Model of the link engine and hub: answers each launch with a result.
// Assumes launch is a one-cycle pulse and dly is at least 1.
`timescale 1ns/10ps
`default_nettype none
module link_engine_model (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        launch,
    input  wire logic [2:0]  code,
    input  wire logic [10:0] bytes,
    input  wire logic [3:0]  dly,
    output var  logic        result_valid,
    output var  logic [2:0]  result_code,
    output var  logic [10:0] result_bytes
);
    logic [3:0] cnt_reg;
    // Result lines invert every cycle outside the pulse and the launch cycle, so a stale code is never read as live
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
            result_valid <= 1'b0;
            result_code <= 3'h7;
            result_bytes <= 11'h7ff;
        end else if (launch) begin
            cnt_reg <= dly;
        end else if (cnt_reg == 4'h1) begin
            cnt_reg <= 4'h0;
            result_valid <= 1'b1;
            result_code <= code;
            result_bytes <= bytes;
        end else begin
            cnt_reg <= (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
            result_valid <= 1'b0;
            result_code <= ~result_code;
            result_bytes <= ~result_bytes;
        end
    end
endmodule
`default_nettype wire

/* testbench/split_bulk_descriptor_decode_tb_top.sv */
// Self-checking bench for the split descriptor decoder.
// Assumes the link engine model answers every launch.
`timescale 1ns/10ps
`default_nettype none
`include "split_desc_defs.vh"
module split_bulk_descriptor_decode_tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sched_req = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [2:0]  code = 3'h0, result_code;
    logic [3:0]  dly = 4'h2, endpoint_index;
    logic [10:0] result_bytes, packet_len;
    logic [6:0]  hub_target_address, hub_port_index, function_address;
    logic [15:0] payload_buffer_pointer;
    logic launch, skipped, busy, split_en, low_speed, ep_is_bulk, result_valid, active;
    logic [1:0]  pid_code;
    int n_errors = 0;
    int samples_checked = 0;
    always #2.5 core_clk = ~core_clk;

    split_bulk_descriptor_decode #(.ADDR_W(8)) split_bulk_descriptor_decode_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sched_req(sched_req),
        .launch(launch), .skipped(skipped), .busy(busy),
        .hub_target_address(hub_target_address), .hub_port_index(hub_port_index),
        .split_en(split_en), .low_speed(low_speed), .pid_code(pid_code),
        .ep_is_bulk(ep_is_bulk), .function_address(function_address),
        .endpoint_index(endpoint_index), .packet_len(packet_len),
        .payload_buffer_pointer(payload_buffer_pointer), .result_valid(result_valid),
        .result_code(result_code), .result_bytes(result_bytes), .active(active));
    link_engine_model link_engine_model_i (
        .core_clk(core_clk), .rst_n(rst_n), .launch(launch), .code(code),
        .bytes(11'h040), .dly(dly), .result_valid(result_valid),
        .result_code(result_code), .result_bytes(result_bytes));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // One scheduler request; result code c comes back from the model
    task automatic go(input logic [2:0] c, input logic lx, input logic [31:0] ef, ep);
        @(posedge core_clk);
        sched_req <= 1'b1;
        code <= c;
        @(posedge core_clk);
        sched_req <= 1'b0;
        #1;
        chk({30'h0, launch, skipped}, {30'h0, lx, !lx});
        if (lx) begin
            chk({2'h0, hub_target_address, hub_port_index, split_en, low_speed, pid_code,
                ep_is_bulk, function_address, endpoint_index}, ef);
            chk({5'h0, packet_len, payload_buffer_pointer}, ep);
            // A second request while busy must be ignored
            @(posedge core_clk);
            sched_req <= 1'b1;
            @(posedge core_clk);
            sched_req <= 1'b0;
            #1;
            chk({30'h0, launch, skipped}, 32'h0);
        end
        for (int i = 0; i < 20 && busy; i++) @(posedge core_clk) #1;
        chk({31'h0, busy}, 32'h0);
    endtask
    task automatic t_reset;
        for (int a = 0; a <= 24; a += 4) rd(a[7:0], (a == 20) ? 32'h400 : 32'h0);
        $display("reset test done");
    endtask
    // Low-speed split: every field, the 64-byte cap, completion on byte total
    task automatic t_decode;
        logic [31:0] f = {2'h0, 7'h55, 7'h2a, 1'b1, 1'b1, 2'h1, 1'b1, 7'h33, 4'hb};
        wr(`OFS_DESC_W1, {7'h55, 7'h2a, 2'h2, 1'b0, 1'b1, 2'h2, 2'h1, 7'h33, 3'h5});
        wr(`OFS_DESC_W2, {7'h0, 1'b0, 16'h1234, 8'h00});
        wr(`OFS_DESC_W0, {1'b1, 2'h0, 11'h200, 15'h0080, 2'h0, 1'b1});
        rd(`OFS_XLATE, 32'h1234 * 8 + 32'h400);
        go(`RES_ACK, 1'b1, f, {5'h0, 11'h040, 16'h1234});
        chk({31'h0, active}, 32'h1);
        go(`RES_ACK, 1'b1, f, {5'h0, 11'h040, 16'h1234});
        chk({31'h0, active}, 32'h0);
        rd(`OFS_DESC_W3, 32'h00000080);
        go(`RES_ACK, 1'b0, f, f);
        $display("decode test done");
    endtask
    // High-speed NAK retries, then reload zero ignoring the counter
    task automatic t_nak;
        logic [31:0] f = {2'h0, 7'h55, 7'h2a, 1'b0, 1'b0, 2'h1, 1'b1, 7'h33, 4'hb};
        logic [31:0] p = {5'h0, 11'h080, 16'h1234};
        dly = 4'h5;
        wr(`OFS_DESC_W1, {7'h55, 7'h2a, 2'h2, 1'b0, 1'b0, 2'h2, 2'h1, 7'h33, 3'h5});
        wr(`OFS_DESC_W2, {3'h0, 4'h2, 1'b0, 16'h1234, 8'h00});
        wr(`OFS_DESC_W3, 32'h00100000);
        wr(`OFS_DESC_W0, {1'b1, 2'h0, 11'h200, 15'h0080, 2'h0, 1'b1});
        go(`RES_NAK, 1'b1, f, p);
        rd(`OFS_DESC_W3, 32'h01880000);
        go(`RES_NAK, 1'b1, f, p);
        chk({31'h0, active}, 32'h0);
        wr(`OFS_DESC_W2, {7'h0, 1'b0, 16'h1234, 8'h00});
        wr(`OFS_DESC_W3, 32'h0);
        wr(`OFS_DESC_W0, {1'b1, 2'h0, 11'h200, 15'h0080, 2'h0, 1'b1});
        repeat (3) go(`RES_NAK, 1'b1, f, p);
        chk({31'h0, active}, 32'h1);
        dly = 4'h2;
        $display("retry test done");
    endtask
    // Every class and token code on a full-speed split; reserved codes are skipped
    task automatic t_modes;
        for (int k = 0; k < 16; k++) begin
            wr(`OFS_DESC_W1, {7'h11, 7'h05, 2'h0, 1'b0, 1'b1, k[3:2], k[1:0], 7'h7f, 3'h0});
            go(`RES_NYET, k[1:0] != 2'h3 && !k[2], {2'h0, 7'h11, 7'h05, 1'b1, 1'b0, k[1:0],
                k[3:2] == 2'h2, 7'h7f, 4'h1}, {5'h0, 11'h040, 16'h1234});
        end
        rd(`OFS_DESC_W3, 32'h01800000);
        $display("mode test done");
    endtask
    // Split errors and fatal results end the descriptor
    task automatic t_err;
        logic [2:0] c[3] = '{`RES_NO_RESP, `RES_BAD_RESP, `RES_FATAL};
        wr(`OFS_DESC_W1, {7'h11, 7'h05, 2'h0, 1'b0, 1'b1, 2'h2, 2'h0, 7'h7f, 3'h0});
        for (int k = 0; k < 3; k++) begin
            wr(`OFS_DESC_W3, 32'h00800000);
            wr(`OFS_DESC_W0, {1'b1, 2'h0, 11'h200, 15'h0080, 2'h0, 1'b1});
            go(c[k], 1'b1, {2'h0, 7'h11, 7'h05, 1'b1, 1'b0, 2'h0, 1'b1, 7'h7f, 4'h1},
                {5'h0, 11'h040, 16'h1234});
            chk({31'h0, active}, 32'h0);
        end
        rd(`OFS_DESC_W3, 32'h00800000);
        $display("error test done");
    endtask
    // Cut a hang short after well over the expected run time
    initial begin
        #(5 * 20000);
        chk(32'h1, 32'h0);
        conclude();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_decode();
        t_nak();
        t_modes();
        t_err();
        conclude();
    end
endmodule
`default_nettype wire
